// *** bcr_pkg.sv ***
// package: register map, field layout, reset values and carriers for the bridge control register block
package bcr_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_INT_BRIDGE = 8'h3c;  // interrupt line/pin and bridge control
  localparam logic [7:0] OFF_PM_CAP = 8'h40;      // power management capability header
  localparam logic [7:0] OFF_OVERRIDE = 8'h80;    // management override of read-only defaults
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h84;  // sticky event status, cleared by read
  localparam logic [7:0] OFF_IRQ_MASK = 8'h88;    // event mask

  // bridge control field positions
  localparam int BIT_POISON_RESP = 16;
  localparam int BIT_ERR_FWD = 17;
  localparam int BIT_LEGACY_IO = 18;
  localparam int BIT_VGA_EN = 19;
  localparam int BIT_VGA_16 = 20;
  localparam int BIT_SEC_RESET = 22;

  // capability fixed values
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] NEXT_PTR_UP = 8'h5c;
  localparam logic [7:0] NEXT_PTR_DOWN = 8'h4c;
  localparam logic [2:0] PM_REVISION = 3'h3;

  // overridable defaults
  localparam logic [7:0] RST_INT_PIN = 8'h00;
  localparam logic RST_DEV_INIT = 1'h0;
  localparam logic [2:0] RST_AUX_CURRENT = 3'h7;
  localparam logic RST_D1 = 1'h1;
  localparam logic RST_D2 = 1'h1;
  localparam logic [4:0] RST_PME_SUPPORT = 5'h1f;

  // event status bit positions
  localparam int EV_POISON = 0;
  localparam int EV_ERR = 1;
  localparam int EV_RESET = 2;
  localparam int EV_NUM = 3;

  // bridge control writable fields
  typedef struct packed {
    logic poison_resp;
    logic err_fwd;
    logic legacy_io;
    logic vga_en;
    logic vga_16;
    logic sec_reset;
  } bcr_ctrl_s;

  // overridable read-only defaults
  typedef struct packed {
    logic [7:0] int_pin;
    logic dev_init;
    logic [2:0] aux_current;
    logic d1;
    logic d2;
    logic [4:0] pme_support;
  } bcr_ovr_s;

endpackage : bcr_pkg

// *** bcr_regs.sv ***
// module: bridge control and power management capability register logic for one port
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// register map as seen on the plain register port
//
// 3ch bridge word
//   [7:0]   interrupt line, read/write scratch for software
//   [15:8]  interrupt pin, read-only, default from the override set
//   [16]    poison response enable
//   [17]    secondary error forwarding enable
//   [18]    legacy io alias forwarding
//   [19]    vga forwarding enable
//   [20]    vga 16-bit io decode
//   [21]    hardwired zero
//   [22]    secondary bus reset
//   [31:23] hardwired zero
//
// 40h power management capability header, all read-only
//   [7:0]   capability id
//   [15:8]  next pointer, depends on port role
//   [18:16] revision
//   [20:19] zero
//   [21]    device specific init, overridable
//   [24:22] aux current, overridable
//   [25]    d1 support, overridable
//   [26]    d2 support, overridable
//   [31:27] pme support, overridable
//
// 80h readback of the override set, 84h sticky status, 88h mask
//
////////////////////////////////////////////////////////////////////////////
// timing
//
// a read strobe at edge n puts the word on rdata after edge n; rdata is
// zero in every other cycle, so a bus without a read valid can or the ports
// together. writes land at the strobe edge and take effect in the next cycle.
// datapath decodes are one flop deep: an address or pulse sampled at edge n
// shows on its output after edge n. the upstream reset level is treated as
// foreign and passes two flops, so a downstream port's reset follows it after three
// edges. a read of the status word clears it, but an event in the same cycle
// is kept so that no event is ever lost between a read and its clear.
//
////////////////////////////////////////////////////////////////////////////
module bcr_regs #(
  parameter bit IS_UPSTREAM = 1'b0  // port role
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,             // register byte address
  input wire logic [31:0] wdata,           // write data
  input wire logic wr,                     // write strobe
  input wire logic rd,                     // read strobe
  input wire logic ovr_wr,                 // management / auto-load strobe for defaults
  input wire bcr_pkg::bcr_ovr_s ovr_data,  // new defaults
  input wire logic upstream_sec_reset,     // upstream port secondary reset level
  input wire logic poison_seen,            // poisoned packet on secondary, pulse
  input wire logic err_msg_seen,           // error message from secondary, pulse
  input wire logic [31:0] io_addr,         // io transaction address
  input wire logic [31:0] mem_addr,        // memory transaction address
  input wire logic io_in_window,           // io address inside io window
  output logic [31:0] rdata,               // read data, cycle after rd
  output logic poison_report,              // poison detected and reported, pulse
  output logic err_forward,                // error message forwarded upstream, pulse
  output logic io_upstream,                // io access goes upstream
  output logic io_downstream,              // io access goes downstream
  output logic vga_mem_hit,                // vga memory range forwarded
  output logic vga_io_hit,                 // vga io range forwarded
  output logic port_reset_n,               // reset to attached devices
  output logic irq                         // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    bcr_pkg::bcr_ctrl_s ctrl;
    bcr_pkg::bcr_ovr_s ovr;
    logic [bcr_pkg::EV_NUM-1:0] status;
    logic [bcr_pkg::EV_NUM-1:0] mask;
    logic [7:0] int_line;
    logic [31:0] rdata;
    logic poison_report;
    logic err_forward;
    logic io_upstream;
    logic io_downstream;
    logic vga_mem_hit;
    logic vga_io_hit;
    logic port_reset_n;
    logic irq;
    logic upr_s1;   // synchroniser first stage
    logic upr_s2;   // synchroniser second stage
  } bcr_state_s;

  bcr_state_s st;       // registered state
  bcr_state_s next_st;  // next state

  logic [31:0] bridge_word;  // assembled 3ch word
  logic [31:0] pm_word;      // assembled 40h word
  localparam int EV_NUM_W = bcr_pkg::EV_NUM;
  logic [EV_NUM_W-1:0] ev;   // events this cycle
  logic legacy_alias;        // address in isa alias area
  logic vga_io_low;          // low ten bits in vga ranges
  logic reset_req;           // reset requested

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state
  always_comb
  begin
    next_st = st;
    // read-only fields assembled; reserved and legacy bits zero
    bridge_word = 32'h0;
    bridge_word[7:0] = st.int_line;
    bridge_word[15:8] = st.ovr.int_pin;
    bridge_word[bcr_pkg::BIT_POISON_RESP] = st.ctrl.poison_resp;
    bridge_word[bcr_pkg::BIT_ERR_FWD] = st.ctrl.err_fwd;
    bridge_word[bcr_pkg::BIT_LEGACY_IO] = st.ctrl.legacy_io;
    bridge_word[bcr_pkg::BIT_VGA_EN] = st.ctrl.vga_en;
    bridge_word[bcr_pkg::BIT_VGA_16] = st.ctrl.vga_16;
    bridge_word[bcr_pkg::BIT_SEC_RESET] = st.ctrl.sec_reset;
    pm_word = 32'h0;
    pm_word[7:0] = bcr_pkg::PM_CAP_ID;
    pm_word[15:8] = IS_UPSTREAM ? bcr_pkg::NEXT_PTR_UP : bcr_pkg::NEXT_PTR_DOWN;
    pm_word[18:16] = bcr_pkg::PM_REVISION;
    pm_word[21] = st.ovr.dev_init;
    pm_word[24:22] = st.ovr.aux_current;
    pm_word[25] = st.ovr.d1;
    pm_word[26] = st.ovr.d2;
    pm_word[31:27] = st.ovr.pme_support;
    // datapath decodes
    next_st.poison_report = poison_seen & st.ctrl.poison_resp;
    next_st.err_forward = err_msg_seen & st.ctrl.err_fwd;
    legacy_alias = (io_addr[31:16] == 16'h0) && (io_addr[9:8] != 2'h0);
    next_st.io_upstream = io_in_window & st.ctrl.legacy_io & legacy_alias;
    next_st.io_downstream = io_in_window & ~(st.ctrl.legacy_io & legacy_alias);
    next_st.vga_mem_hit = st.ctrl.vga_en && (mem_addr >= 32'h000a0000) && (mem_addr <= 32'h000bffff);
    vga_io_low = ((io_addr[9:0] >= 10'h3b0) && (io_addr[9:0] <= 10'h3bb)) ||
                 ((io_addr[9:0] >= 10'h3c0) && (io_addr[9:0] <= 10'h3df));
    next_st.vga_io_hit = st.ctrl.vga_en && vga_io_low && (io_addr[31:16] == 16'h0) &&
                         (!st.ctrl.vga_16 || (io_addr[15:10] == 6'h0));
    // upstream reset level crosses in through two flops
    next_st.upr_s1 = upstream_sec_reset;
    next_st.upr_s2 = st.upr_s1;
    reset_req = st.ctrl.sec_reset | (~IS_UPSTREAM & st.upr_s2);
    next_st.port_reset_n = ~reset_req;
    ev = '0;
    ev[bcr_pkg::EV_POISON] = next_st.poison_report;
    ev[bcr_pkg::EV_ERR] = next_st.err_forward;
    ev[bcr_pkg::EV_RESET] = reset_req & st.port_reset_n;
    // management override of defaults
    if (ovr_wr)
    begin
      next_st.ovr = ovr_data;
    end
    // register writes
    if (wr && addr == bcr_pkg::OFF_INT_BRIDGE)
    begin
      next_st.int_line = wdata[7:0];
      next_st.ctrl.poison_resp = wdata[bcr_pkg::BIT_POISON_RESP];
      next_st.ctrl.err_fwd = wdata[bcr_pkg::BIT_ERR_FWD];
      next_st.ctrl.legacy_io = wdata[bcr_pkg::BIT_LEGACY_IO];
      next_st.ctrl.vga_en = wdata[bcr_pkg::BIT_VGA_EN];
      next_st.ctrl.vga_16 = wdata[bcr_pkg::BIT_VGA_16];
      next_st.ctrl.sec_reset = wdata[bcr_pkg::BIT_SEC_RESET];
    end
    else if (wr && addr == bcr_pkg::OFF_IRQ_MASK)
    begin
      next_st.mask = wdata[EV_NUM_W-1:0];
    end
    // reads; status cleared on read, new events win
    next_st.rdata = 32'h0;
    if (rd)
    begin
      unique case (addr)
        bcr_pkg::OFF_INT_BRIDGE: next_st.rdata = bridge_word;
        bcr_pkg::OFF_PM_CAP: next_st.rdata = pm_word;
        bcr_pkg::OFF_OVERRIDE: next_st.rdata = {13'h0, st.ovr};
        bcr_pkg::OFF_IRQ_STATUS:
        begin
          next_st.rdata = {29'h0, st.status};
          next_st.status = '0;
        end
        bcr_pkg::OFF_IRQ_MASK: next_st.rdata = {29'h0, st.mask};
        default: next_st.rdata = 32'h0;  // unmapped reads zero
      endcase
    end
    next_st.status = next_st.status | ev;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.ovr <= {bcr_pkg::RST_INT_PIN, bcr_pkg::RST_DEV_INIT, bcr_pkg::RST_AUX_CURRENT,
                 bcr_pkg::RST_D1, bcr_pkg::RST_D2, bcr_pkg::RST_PME_SUPPORT};
      st.port_reset_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata = st.rdata;
  assign poison_report = st.poison_report;
  assign err_forward = st.err_forward;
  assign io_upstream = st.io_upstream;
  assign io_downstream = st.io_downstream;
  assign vga_mem_hit = st.vga_mem_hit;
  assign vga_io_hit = st.vga_io_hit;
  assign port_reset_n = st.port_reset_n;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // every property samples on the rising clock and is off during reset.
  // the checks look at the registered outputs (a_ovr at st.ovr) one cycle after the cause,
  // which is the latency the user of this block sees.
  // read checks look at rdata in the cycle after the strobe only.
  // decode checks cover both sides of poison_resp, err_fwd and legacy_io; vga_en is checked disabled only and vga_16 enabled only.
  property p_vgaio;
    @(posedge clk) disable iff (!reset_n) !st.ctrl.vga_en |=> !vga_io_hit;
  endproperty
  a_vgaio: assert property (p_vgaio) else $error("vga io forwarded while disabled");

  property p_vga16;
    @(posedge clk) disable iff (!reset_n) st.ctrl.vga_16 && io_addr[15:10] != 6'h0 |=> !vga_io_hit;
  endproperty
  a_vga16: assert property (p_vga16) else $error("vga io hit with upper bits in 16-bit mode");

  property p_ioup;
    @(posedge clk) disable iff (!reset_n)
      io_in_window && st.ctrl.legacy_io && io_addr[31:16] == 16'h0 && io_addr[9:8] != 2'h0 |=>
      io_upstream && !io_downstream;
  endproperty
  a_ioup: assert property (p_ioup) else $error("legacy alias not sent upstream");

  property p_poisonen;
    @(posedge clk) disable iff (!reset_n) poison_seen && st.ctrl.poison_resp |=> poison_report;
  endproperty
  a_poisonen: assert property (p_poisonen) else $error("poison not reported while enabled");

  property p_nextptr;
    @(posedge clk) disable iff (!reset_n) rd && addr == bcr_pkg::OFF_PM_CAP |=>
      rdata[15:8] == (IS_UPSTREAM ? 8'h5c : 8'h4c);
  endproperty
  a_nextptr: assert property (p_nextptr) else $error("next pointer wrong");

  property p_memout;
    @(posedge clk) disable iff (!reset_n) mem_addr > 32'h000bffff || mem_addr < 32'h000a0000 |=> !vga_mem_hit;
  endproperty
  a_memout: assert property (p_memout) else $error("vga memory hit outside range");

  property p_ovr;
    @(posedge clk) disable iff (!reset_n) ovr_wr |=> st.ovr == $past(ovr_data);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not loaded");

  property p_pmrsvd;
    @(posedge clk) disable iff (!reset_n) rd && addr == bcr_pkg::OFF_PM_CAP |=> rdata[20] == 1'b0;
  endproperty
  a_pmrsvd: assert property (p_pmrsvd) else $error("reserved capability bit set");

  property p_poison;
    @(posedge clk) disable iff (!reset_n) poison_seen && !st.ctrl.poison_resp |=> !poison_report;
  endproperty
  a_poison: assert property (p_poison) else $error("poison reported while disabled");

  property p_errfwd;
    @(posedge clk) disable iff (!reset_n) err_msg_seen |=> (err_forward == $past(st.ctrl.err_fwd));
  endproperty
  a_errfwd: assert property (p_errfwd) else $error("error forward not gated");

  property p_secrst;
    @(posedge clk) disable iff (!reset_n) st.ctrl.sec_reset |=> !port_reset_n;
  endproperty
  a_secrst: assert property (p_secrst) else $error("port reset not asserted");

  property p_uprst;
    @(posedge clk) disable iff (!reset_n) (!IS_UPSTREAM && upstream_sec_reset) [*3] |=> !port_reset_n;
  endproperty
  a_uprst: assert property (p_uprst) else $error("upstream reset not propagated");

  property p_pmread;
    @(posedge clk) disable iff (!reset_n) rd && addr == bcr_pkg::OFF_PM_CAP |=>
      rdata[7:0] == 8'h01 && rdata[18:16] == 3'h3 && rdata[20:19] == 2'h0;
  endproperty
  a_pmread: assert property (p_pmread) else $error("capability read wrong");

  property p_legacy;
    @(posedge clk) disable iff (!reset_n) rd && addr == bcr_pkg::OFF_INT_BRIDGE |=>
      rdata[21] == 1'b0 && rdata[31:23] == 9'h0;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy bits not zero");

  property p_vgamem;
    @(posedge clk) disable iff (!reset_n) !st.ctrl.vga_en |=> !vga_mem_hit;
  endproperty
  a_vgamem: assert property (p_vgamem) else $error("vga forwarded while disabled");

  property p_iodir;
    @(posedge clk) disable iff (!reset_n) io_in_window && !st.ctrl.legacy_io |=> io_downstream && !io_upstream;
  endproperty
  a_iodir: assert property (p_iodir) else $error("io window not forwarded downstream");

  c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
  c_vga: cover property (@(posedge clk) disable iff (!reset_n) vga_io_hit);
  c_up: cover property (@(posedge clk) disable iff (!reset_n) io_upstream);
  c_rst: cover property (@(posedge clk) disable iff (!reset_n) $fell(port_reset_n));
  c_poison: cover property (@(posedge clk) disable iff (!reset_n) poison_report);

endmodule : bcr_regs

// *** bcr_link_model.sv ***
// downstream device model: turns bench requests into secondary-side traffic pulses
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
module bcr_link_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_reset_n,  // reset from the switch port
  input wire logic send_poison,   // request a poisoned packet
  input wire logic send_err,      // request an error message
  output logic poison_seen,       // poisoned packet, one cycle
  output logic err_msg_seen       // error message, one cycle
);
  // a device held in reset stays silent
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      poison_seen <= 1'b0;
      err_msg_seen <= 1'b0;
    end
    else
    begin
      poison_seen <= send_poison & port_reset_n;
      err_msg_seen <= send_err & port_reset_n;
    end
  end
endmodule : bcr_link_model

// *** bcr_regs_tb.sv ***
// testbench for the bridge control and power management register block
`timescale 1ns/100ps
module bcr_regs_tb;
  // decode case: control bits, addresses, window, expected {up, down, mem, io}
  typedef struct packed {logic [2:0] ctl; logic [31:0] io; logic [31:0] mem; logic win; logic [3:0] exp;} bcr_dec_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, io_addr = 32'h0, mem_addr = 32'h0, rdata, rdata_up, up_seen;
  logic wr = 1'b0, rd = 1'b0, ovr_wr = 1'b0, up_rst = 1'b0, win = 1'b0, send_poison = 1'b0, send_err = 1'b0;
  bcr_pkg::bcr_ovr_s ovr_data = 19'h0;
  logic poison_seen, err_msg_seen, poison_report, err_forward, io_up, io_down, mem_hit, vio_hit, port_reset_n, irq;
  int mismatches = 0, n_tests = 0, cycles = 0;
  bcr_dec_s tbl [16] = '{
    '{3'h1, 32'h100, 32'h0, 1'b1, 4'h8}, '{3'h1, 32'h0ff, 32'h0, 1'b1, 4'h4},
    '{3'h1, 32'h10100, 32'h0, 1'b1, 4'h4}, '{3'h0, 32'h100, 32'h0, 1'b1, 4'h4},
    '{3'h2, 32'h0, 32'h000a0000, 1'b0, 4'h2}, '{3'h2, 32'h0, 32'h000bffff, 1'b0, 4'h2},
    '{3'h2, 32'h0, 32'h000c0000, 1'b0, 4'h0}, '{3'h0, 32'h0, 32'h000a0000, 1'b0, 4'h0},
    '{3'h2, 32'h3b0, 32'h0, 1'b0, 4'h1}, '{3'h2, 32'h3bc, 32'h0, 1'b0, 4'h0},
    '{3'h2, 32'h3df, 32'h0, 1'b0, 4'h1}, '{3'h2, 32'h13c0, 32'h0, 1'b0, 4'h1},
    '{3'h6, 32'h13c0, 32'h0, 1'b0, 4'h0}, '{3'h6, 32'h3c0, 32'h0, 1'b0, 4'h1},
    '{3'h2, 32'h103b0, 32'h0, 1'b0, 4'h0}, '{3'h0, 32'h3b0, 32'h0, 1'b0, 4'h0}};
  ////////////////////////////////////////////////////////////////
  // clock and instances
  always #10 clk = ~clk;
  bcr_regs #(.IS_UPSTREAM(1'b0)) bcr_regs_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .ovr_wr(ovr_wr), .ovr_data(ovr_data), .upstream_sec_reset(up_rst), .poison_seen(poison_seen),
    .err_msg_seen(err_msg_seen), .io_addr(io_addr), .mem_addr(mem_addr), .io_in_window(win), .rdata(rdata),
    .poison_report(poison_report), .err_forward(err_forward), .io_upstream(io_up), .io_downstream(io_down),
    .vga_mem_hit(mem_hit), .vga_io_hit(vio_hit), .port_reset_n(port_reset_n), .irq(irq));
  // upstream port copy, used for its capability pointer
  bcr_regs #(.IS_UPSTREAM(1'b1)) bcr_regs_up_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .ovr_wr(1'b0), .ovr_data(ovr_data), .upstream_sec_reset(1'b0), .poison_seen(poison_seen),
    .err_msg_seen(err_msg_seen), .io_addr(io_addr), .mem_addr(mem_addr), .io_in_window(win), .rdata(rdata_up),
    .poison_report(), .err_forward(), .io_upstream(), .io_downstream(), .vga_mem_hit(), .vga_io_hit(),
    .port_reset_n(), .irq());
  bcr_link_model bcr_link_model_i (.clk(clk), .reset_n(reset_n), .port_reset_n(port_reset_n),
    .send_poison(send_poison), .send_err(send_err), .poison_seen(poison_seen), .err_msg_seen(err_msg_seen));
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // one-cycle read, data compared in the following cycle
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    up_seen = rdata_up;
    check(rdata, exp);
  endtask : reg_rd
  // wait some edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // ask the device model for traffic; returns where the port's answer stands
  task automatic send(input logic p, input logic e);
    @(posedge clk);
    send_poison <= p;
    send_err <= e;
    @(posedge clk);
    send_poison <= 1'b0;
    send_err <= 1'b0;
    tick(1);
  endtask : send
  // counts, verdict, end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      final_report();
    end
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(bcr_pkg::OFF_INT_BRIDGE, 32'h0);
    reg_rd(bcr_pkg::OFF_PM_CAP, 32'hffc34c01);
    check(up_seen, 32'hffc35c01);
    reg_wr(bcr_pkg::OFF_INT_BRIDGE, 32'hffffffff);
    reg_rd(bcr_pkg::OFF_INT_BRIDGE, 32'h005f00ff);
    check(port_reset_n, 1'b0);
    reg_wr(bcr_pkg::OFF_INT_BRIDGE, 32'h0);
    reg_wr(bcr_pkg::OFF_PM_CAP, 32'h0);
    reg_rd(bcr_pkg::OFF_PM_CAP, 32'hffc34c01);
    check(port_reset_n, 1'b1);
    reg_rd(bcr_pkg::OFF_IRQ_STATUS, 32'h4);
    reg_rd(8'h90, 32'h0);
    // management override of the read-only defaults
    @(posedge clk);
    ovr_data <= {8'h01, 1'b1, 3'h0, 1'b0, 1'b0, 5'h00};
    ovr_wr <= 1'b1;
    @(posedge clk);
    ovr_wr <= 1'b0;
    reg_rd(bcr_pkg::OFF_PM_CAP, 32'h00234c01);
    reg_rd(bcr_pkg::OFF_INT_BRIDGE, 32'h00000100);
    // poisoned packets and error messages, gated then enabled
    send(1'b1, 1'b1);
    check({poison_report, err_forward}, 2'b00);
    reg_wr(bcr_pkg::OFF_INT_BRIDGE, 32'h00030000);
    send(1'b1, 1'b0);
    check({poison_report, err_forward}, 2'b10);
    send(1'b0, 1'b1);
    check({poison_report, err_forward}, 2'b01);
    // sticky status, mask and level interrupt
    reg_rd(bcr_pkg::OFF_IRQ_STATUS, 32'h3);
    reg_rd(bcr_pkg::OFF_IRQ_STATUS, 32'h0);
    reg_wr(bcr_pkg::OFF_IRQ_MASK, 32'h1);
    reg_rd(bcr_pkg::OFF_IRQ_MASK, 32'h1);
    send(1'b0, 1'b1);
    tick(2);
    check(irq, 1'b0);
    send(1'b1, 1'b0);
    tick(2);
    check(irq, 1'b1);
    reg_rd(bcr_pkg::OFF_IRQ_STATUS, 32'h3);
    tick(2);
    check(irq, 1'b0);
    // address decode table
    foreach (tbl[i])
    begin
      reg_wr(bcr_pkg::OFF_INT_BRIDGE, {11'h0, tbl[i].ctl, 18'h0});
      io_addr <= tbl[i].io;
      mem_addr <= tbl[i].mem;
      win <= tbl[i].win;
      tick(2);
      check({io_up, io_down, mem_hit, vio_hit}, tbl[i].exp);
    end
    // reset request from the upstream port
    up_rst <= 1'b1;
    tick(4);
    check(port_reset_n, 1'b0);
    up_rst <= 1'b0;
    tick(4);
    check(port_reset_n, 1'b1);
    final_report();
  end
endmodule : bcr_regs_tb
